// File: bas_bargraph_bank.sv
// Top: display value select, auto return, output test and bank thresholds
`timescale 1ns/1ps
module bas_bargraph_bank #(
	parameter int TICK_CYC = bas_pkg::TICK_CYC,
	parameter int HOLD_MS  = bas_pkg::HOLD_MS
) (
	input  wire logic                              clk_sys_in,
	input  wire logic                              rst_n_in,
	input  wire logic signed [bas_pkg::VAL_W-1:0]  meas_in,
	input  wire logic signed [bas_pkg::VAL_W-1:0]  max_in,
	input  wire logic signed [bas_pkg::VAL_W-1:0]  min_in,
	input  wire logic [1:0]                        disp_sel_in,
	input  wire logic [1:0]                        disp_power_on_in,
	input  wire logic                              disp_switch_in,
	input  wire logic                              run_or_adj_in,
	input  wire bas_pkg::bas_keys_s                keys_in,
	input  wire logic [6:0]                        ret_time_s_in,
	input  wire bas_pkg::bas_meter_e               mtype_in,
	input  wire logic signed [bas_pkg::VAL_W-1:0]  meter_upper_in,
	input  wire logic signed [bas_pkg::VAL_W-1:0]  meter_lower_in,
	input  wire logic                              test_level_in,
	input  wire logic                              test_enable_in,
	input  wire bas_pkg::bas_bank_e                bank_method_in,
	input  wire logic                              set_protect_in,
	input  wire logic [bas_pkg::BANK_W-1:0]        key_bank_in,
	input  wire logic                              bank_sel_bit0,
	input  wire logic                              bank_sel_bit1,
	input  wire logic                              bank_sel_bit2,
	input  wire logic                              bank_thresh_edit,
	input  wire logic                              run_thresh_wr_in,
	input  wire logic [bas_pkg::BANK_W-1:0]        edit_bank_in,
	input  wire bas_pkg::bas_thresh_s              thresh_wdata_in,
	input  wire logic                              copy_go_in,
	input  wire logic [bas_pkg::BANK_W-1:0]        copy_src_in,
	output logic [bas_pkg::SEGS-1:0]               segs_out,
	output logic [1:0]                             disp_sel_out,
	output logic signed [bas_pkg::VAL_W-1:0]       test_value_out,
	output logic                                   test_active_out,
	output logic [bas_pkg::BANK_W-1:0]             active_bank_out,
	output bas_pkg::bas_thresh_s                   thresh_out,
	output bas_pkg::bas_cmp_s                      cmp_out,
	output logic                                   bank_lit_out,
	output logic                                   method_visible_out,
	output logic                                   edit_refused_out
);
	localparam int TW = 17;
	localparam int MW = 10;

	typedef struct packed {
		logic [TW-1:0]                       tick_cnt;
		logic [MW-1:0]                       ms_cnt;
		logic [6:0]                          idle_s;
		logic                                ret_armed;
		logic [1:0]                          disp;
		logic signed [bas_pkg::VAL_W-1:0]    tval;
		logic                                tact;
		logic [MW-1:0]                       hold_ms;
		logic [MW-1:0]                       rep_ms;
		logic                                was_key;
		logic [bas_pkg::BANK_W-1:0]          bank;
		bas_pkg::bas_thresh_s                thr;
		bas_pkg::bas_cmp_s                   cmp;
		logic                                refused;
		logic                                lit;
		logic                                vis;
		bas_pkg::bas_thresh_s [bas_pkg::NUM_BANKS-1:0] banks;
	} bas_top_state_s;

	bas_top_state_s st_r;
	bas_top_state_s st_nxt;
	logic signed [bas_pkg::VAL_W-1:0] shown;
	logic signed [bas_pkg::VAL_W-1:0] cmp_val;
	logic                             tick;
	logic                             key_held;
	logic [MW-1:0]                    rep_period;

	function automatic logic signed [bas_pkg::VAL_W-1:0] clamp_val(
		input logic signed [bas_pkg::VAL_W-1:0] v);
		if (v > bas_pkg::VAL_MAX)
			return bas_pkg::VAL_MAX;
		if (v < bas_pkg::VAL_MIN)
			return bas_pkg::VAL_MIN;
		return v;
	endfunction

	// Values passed in so the caller sees every change
	function automatic logic signed [bas_pkg::VAL_W-1:0] pick_val(
		input logic [1:0]                       sel,
		input logic signed [bas_pkg::VAL_W-1:0] pres,
		input logic signed [bas_pkg::VAL_W-1:0] maxv,
		input logic signed [bas_pkg::VAL_W-1:0] minv);
		case (sel)
			2'h1:    return maxv;
			2'h2:    return minv;
			default: return pres;
		endcase
	endfunction

	always_comb
	begin
		st_nxt = st_r;
		tick = (st_r.tick_cnt == TW'(TICK_CYC - 1));
		st_nxt.tick_cnt = tick ? '0 : st_r.tick_cnt + 1'b1;
		key_held = keys_in.up | keys_in.shift;

		// One-second count from millisecond ticks
		if (tick)
			st_nxt.ms_cnt = (st_r.ms_cnt == MW'(bas_pkg::MS_PER_SEC - 1)) ? '0
				: st_r.ms_cnt + 1'b1;

		// Display selection and idle return
		if (disp_switch_in && run_or_adj_in)
		begin
			st_nxt.disp = disp_sel_in;
			st_nxt.ret_armed = 1'b1;
		end
		if (keys_in.any || disp_switch_in)
		begin
			st_nxt.idle_s = '0;
			st_nxt.ms_cnt = '0;
		end
		else if (tick && st_r.ms_cnt == MW'(bas_pkg::MS_PER_SEC - 1) && st_r.ret_armed)
			st_nxt.idle_s = st_r.idle_s + 1'b1;
		if (ret_time_s_in == 7'h00)
			st_nxt.idle_s = '0;
		else if (st_r.ret_armed && run_or_adj_in && !disp_switch_in && !keys_in.any
			&& st_r.idle_s >= ret_time_s_in)
		begin
			st_nxt.disp = disp_power_on_in;
			st_nxt.ret_armed = 1'b0;
			st_nxt.idle_s = '0;
		end

		st_nxt.tact = test_level_in && test_enable_in;
		rep_period = (st_r.hold_ms >= MW'(HOLD_MS)) ? MW'(bas_pkg::REP_FAST_MS)
			: MW'(bas_pkg::REP_SLOW_MS);
		if (!key_held || !st_r.tact)
		begin
			st_nxt.hold_ms = '0;
			st_nxt.rep_ms = '0;
		end
		else if (tick)
		begin
			if (st_r.hold_ms < MW'(HOLD_MS))
				st_nxt.hold_ms = st_r.hold_ms + 1'b1;
			st_nxt.rep_ms = (st_r.rep_ms >= rep_period - 1'b1) ? '0 : st_r.rep_ms + 1'b1;
		end
		st_nxt.was_key = key_held;
		// Up/shift step, held key repeats faster
		if (st_r.tact && ((key_held && !st_r.was_key)
			|| (tick && key_held && st_r.rep_ms >= rep_period - 1'b1)))
		begin
			if (keys_in.up)
				st_nxt.tval = clamp_val(st_r.tval + 18'sd1);
			else
				st_nxt.tval = clamp_val(st_r.tval - 18'sd1);
		end

		st_nxt.vis = !set_protect_in;
		st_nxt.lit = (bank_method_in != bas_pkg::BM_OFF);
		case (bank_method_in)
			bas_pkg::BM_KEYS:
				st_nxt.bank = key_bank_in;
			bas_pkg::BM_EVENT:
				st_nxt.bank = {bank_sel_bit2, bank_sel_bit1, bank_sel_bit0};
			default:
				st_nxt.bank = bas_pkg::BANK_RST;
		endcase

		st_nxt.refused = bank_thresh_edit && (bank_method_in == bas_pkg::BM_OFF);
		if (bank_thresh_edit && bank_method_in != bas_pkg::BM_OFF)
			st_nxt.banks[edit_bank_in] = thresh_wdata_in;
		// Run-level entry lands in bank 0
		if (run_thresh_wr_in)
			st_nxt.banks[0] = thresh_wdata_in;
		if (copy_go_in && bank_method_in != bas_pkg::BM_OFF)
			for (int b = 0; b < bas_pkg::NUM_BANKS; b++)
				st_nxt.banks[b] = st_r.banks[copy_src_in];

		st_nxt.thr = st_r.banks[st_r.bank];
		cmp_val = st_r.tact ? st_r.tval : meas_in;
		st_nxt.cmp.hh = cmp_val > st_r.thr.hh;
		st_nxt.cmp.h  = cmp_val > st_r.thr.h;
		st_nxt.cmp.l  = cmp_val < st_r.thr.l;
		st_nxt.cmp.ll = cmp_val < st_r.thr.ll;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign shown = st_r.tact ? st_r.tval : pick_val(st_r.disp, meas_in, max_in, min_in);

	bas_bar_meter #(
		.SEGS (bas_pkg::SEGS)
	) u_meter (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.value_in   (shown),
		.upper_in   (clamp_val(meter_upper_in)),
		.lower_in   (clamp_val(meter_lower_in)),
		.mtype_in   (mtype_in),
		.segs_out   (segs_out)
	);

	assign disp_sel_out       = st_r.disp;
	assign test_value_out     = st_r.tval;
	assign test_active_out    = st_r.tact;
	assign active_bank_out    = st_r.bank;
	assign thresh_out         = st_r.thr;
	assign cmp_out            = st_r.cmp;
	assign bank_lit_out       = st_r.lit;
	assign method_visible_out = st_r.vis;
	assign edit_refused_out   = st_r.refused;
endmodule

// File: bas_pkg.sv
// Package: constants and carriers for the bar meter, auto return and bank select block
package bas_pkg;
	localparam int VAL_W        = 18;
	localparam int SEGS         = 20;
	localparam int NUM_BANKS    = 8;
	localparam int BANK_W       = 3;
	localparam logic signed [VAL_W-1:0] VAL_MIN = -18'sd19999;
	localparam logic signed [VAL_W-1:0] VAL_MAX = 18'sd99999;
	localparam int CLK_HZ       = 100000000;
	localparam int TICK_MS      = 1;
	localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_PER_SEC   = 1000;
	localparam logic [6:0] RET_MAX_S = 7'h63;
	localparam int HOLD_MS      = 500;
	localparam int REP_SLOW_MS  = 200;
	localparam int REP_FAST_MS  = 20;
	localparam logic [6:0] RET_RST = 7'h00;
	localparam logic [BANK_W-1:0] BANK_RST = 3'h0;

	typedef enum logic [2:0] {
		MT_OFF  = 3'h0,
		MT_INC  = 3'h1,
		MT_INCR = 3'h2,
		MT_DEV  = 3'h3,
		MT_DEVR = 3'h4
	} bas_meter_e;

	typedef enum logic [1:0] {
		BM_OFF   = 2'h0,
		BM_KEYS  = 2'h1,
		BM_EVENT = 2'h2
	} bas_bank_e;

	typedef struct packed {
		logic signed [VAL_W-1:0] hh;
		logic signed [VAL_W-1:0] h;
		logic signed [VAL_W-1:0] l;
		logic signed [VAL_W-1:0] ll;
	} bas_thresh_s;

	typedef struct packed {
		logic hh;
		logic h;
		logic l;
		logic ll;
	} bas_cmp_s;

	typedef struct packed {
		logic up;
		logic shift;
		logic any;
	} bas_keys_s;
endpackage

// File: bas_bar_meter.sv
// Bar meter segment generator
`timescale 1ns/1ps
module bas_bar_meter #(
	parameter int SEGS = bas_pkg::SEGS
) (
	input  wire logic                          clk_sys_in,
	input  wire logic                          rst_n_in,
	input  wire logic signed [bas_pkg::VAL_W-1:0] value_in,
	input  wire logic signed [bas_pkg::VAL_W-1:0] upper_in,
	input  wire logic signed [bas_pkg::VAL_W-1:0] lower_in,
	input  wire bas_pkg::bas_meter_e           mtype_in,
	output logic [SEGS-1:0]                    segs_out
);
	typedef struct packed {
		logic [SEGS-1:0] segs;
	} bas_bm_state_s;

	bas_bm_state_s st_r;
	bas_bm_state_s st_nxt;
	logic signed [19:0] span;
	logic signed [19:0] off;
	logic signed [19:0] scaled;
	logic signed [19:0] mid;
	logic               rev;
	logic               swap;
	int                 lvl;

	always_comb
	begin
		st_nxt = st_r;
		// Span from lower to upper, sign folded below
		span = 20'(upper_in) - 20'(lower_in);
		swap = (lower_in < upper_in);
		rev = (mtype_in == bas_pkg::MT_INCR) || (mtype_in == bas_pkg::MT_DEVR);
		mid = (20'(upper_in) + 20'(lower_in)) >>> 1;
		off = 20'(value_in) - 20'(lower_in);
		if (span < 0)
		begin
			span = -span;
			off = 20'(lower_in) - 20'(value_in);
		end
		if (span == 0)
			span = 20'sd1;
		// Divide is slow logic but runs only in a display path
		// Product kept wide, 20 bits overflow at large limits
		scaled = 20'((32'(off) * 32'sd20) / 32'(span));
		lvl = 0;
		if (scaled > 20'sd20)
			lvl = SEGS;
		else if (scaled > 0)
			lvl = int'(scaled);
		st_nxt.segs = '0;
		case (mtype_in)
			bas_pkg::MT_INC, bas_pkg::MT_INCR:
			begin
				for (int i = 0; i < SEGS; i++)
					st_nxt.segs[i] = (i < lvl);
			end
			bas_pkg::MT_DEV, bas_pkg::MT_DEVR:
			begin
				for (int i = 0; i < SEGS; i++)
					st_nxt.segs[i] = (lvl >= SEGS / 2) ? (i >= SEGS / 2 && i < lvl)
						: (i >= lvl && i < SEGS / 2);
				if (value_in == mid[bas_pkg::VAL_W-1:0])
					st_nxt.segs[SEGS/2] = 1'b1;
			end
			default:
				st_nxt.segs = '0;
		endcase
		if (rev ^ swap)
			st_nxt.segs = {<<{st_nxt.segs}};
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign segs_out = st_r.segs;
endmodule

// File: bas_bargraph_bank_sva.sv
// Port checker for the bar meter, auto return and bank select block
`timescale 1ns/1ps
module bas_bargraph_bank_sva (
	input wire logic                       clk_sys_in,
	input wire logic                       rst_n_in,
	input wire logic [1:0]                 disp_sel_in,
	input wire logic                       disp_switch_in,
	input wire logic                       run_or_adj_in,
	input wire logic [6:0]                 ret_time_s_in,
	input wire bas_pkg::bas_meter_e        mtype_in,
	input wire logic                       test_level_in,
	input wire logic                       test_enable_in,
	input wire bas_pkg::bas_bank_e         bank_method_in,
	input wire logic                       set_protect_in,
	input wire logic [bas_pkg::BANK_W-1:0] key_bank_in,
	input wire logic                       bank_sel_bit0,
	input wire logic                       bank_sel_bit1,
	input wire logic                       bank_sel_bit2,
	input wire logic                       bank_thresh_edit,
	input wire logic [bas_pkg::SEGS-1:0]   segs_out,
	input wire logic [1:0]                 disp_sel_out,
	input wire logic                       test_active_out,
	input wire logic [bas_pkg::BANK_W-1:0] active_bank_out,
	input wire logic                       bank_lit_out,
	input wire logic                       method_visible_out,
	input wire logic                       edit_refused_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_evt;
		bank_method_in == bas_pkg::BM_EVENT;
	endsequence
	sequence s_off3;
		(mtype_in == bas_pkg::MT_OFF) [*3];
	endsequence
	AST_EVT_BANK: assert property (s_evt |=> active_bank_out ==
		$past({bank_sel_bit2, bank_sel_bit1, bank_sel_bit0})) else $error("event bank wrong");
	AST_KEY_BANK: assert property (bank_method_in == bas_pkg::BM_KEYS |=>
		active_bank_out == $past(key_bank_in)) else $error("key bank wrong");
	AST_TEST_ON: assert property (test_level_in && test_enable_in |=>
		test_active_out) else $error("test mode not entered");
	AST_TEST_OFF: assert property (!test_enable_in |=> !test_active_out)
		else $error("test mode while disabled");
	AST_REFUSE: assert property (bank_thresh_edit && bank_method_in == bas_pkg::BM_OFF
		|=> edit_refused_out) else $error("edit not refused");
	AST_NO_REFUSE: assert property (bank_method_in != bas_pkg::BM_OFF |=>
		!edit_refused_out) else $error("edit refused wrongly");
	AST_HIDE: assert property (1'b1 |=> method_visible_out == !$past(set_protect_in))
		else $error("method visibility wrong");
	AST_DISP_SW: assert property (disp_switch_in && run_or_adj_in |=>
		disp_sel_out == $past(disp_sel_in)) else $error("display switch lost");
	AST_NO_RET: assert property (ret_time_s_in == 7'h00 && !disp_switch_in &&
		$stable(run_or_adj_in) |=> $stable(disp_sel_out)) else $error("return at zero time");
	AST_BLANK: assert property (s_off3 |=> segs_out == '0)
		else $error("blanked meter lit");
	AST_BANK_LIT: assert property (1'b1 |=> bank_lit_out ==
		($past(bank_method_in) != bas_pkg::BM_OFF)) else $error("bank lamp wrong");
endmodule
bind bas_bargraph_bank bas_bargraph_bank_sva i_bas_bargraph_bank_sva (.clk_sys_in,
	.rst_n_in, .disp_sel_in, .disp_switch_in, .run_or_adj_in, .ret_time_s_in, .mtype_in,
	.test_level_in, .test_enable_in, .bank_method_in, .set_protect_in, .key_bank_in,
	.bank_sel_bit0, .bank_sel_bit1, .bank_sel_bit2, .bank_thresh_edit, .segs_out,
	.disp_sel_out, .test_active_out, .active_bank_out, .bank_lit_out, .method_visible_out,
	.edit_refused_out);

// File: bas_partner.sv
// Operator key and bank event input model
`timescale 1ns/1ps
module bas_partner (
	input  wire logic          clk_sys_in,
	output bas_pkg::bas_keys_s keys_out,
	output logic [2:0]         ev_bank_out
);
	initial
	begin
		keys_out = '0;
		ev_bank_out = 3'h0;
	end
	task automatic set_bank(input logic [2:0] b);
		@(negedge clk_sys_in);
		ev_bank_out = b;
	endtask
	task automatic hold_key(input logic up, input int cyc);
		@(negedge clk_sys_in);
		keys_out = '{up: up, shift: !up, any: 1'b1};
		repeat (cyc) @(negedge clk_sys_in);
		keys_out = '0;
	endtask
endmodule

// File: bas_bargraph_bank_tb.sv
// Testbench for the bar meter, auto return and bank select block
`timescale 1ns/1ps
module bas_bargraph_bank_tb;
	localparam bas_pkg::bas_thresh_s T1 = {18'h00064, 18'h00032, 18'h3FFCE, 18'h3FF9C};
	localparam bas_pkg::bas_thresh_s T2 = {18'h00400, 18'h00300, 18'h00200, 18'h00100};
	logic clk_sys_in, rst_n_in, disp_switch_in, run_or_adj_in, test_level_in;
	logic test_enable_in, set_protect_in, bank_thresh_edit, run_thresh_wr_in, copy_go_in;
	logic test_active_out, bank_lit_out, method_visible_out, edit_refused_out;
	logic signed [bas_pkg::VAL_W-1:0] meas_in, max_in, min_in, meter_upper_in;
	logic signed [bas_pkg::VAL_W-1:0] meter_lower_in, test_value_out, v1;
	logic [1:0]                       disp_sel_in, disp_power_on_in, disp_sel_out;
	logic [6:0]                       ret_time_s_in;
	logic [2:0]                       key_bank_in, edit_bank_in, copy_src_in, ev_bank;
	logic [2:0]                       active_bank_out;
	logic [bas_pkg::SEGS-1:0]         segs_out;
	bas_pkg::bas_keys_s               keys_in;
	bas_pkg::bas_meter_e              mtype_in;
	bas_pkg::bas_bank_e               bank_method_in;
	bas_pkg::bas_thresh_s             thresh_wdata_in, thresh_out;
	bas_pkg::bas_cmp_s                cmp_out;
	int                               error_cnt, tests_run;
	bas_partner i_bas_partner (.clk_sys_in, .keys_out(keys_in), .ev_bank_out(ev_bank));
	bas_bargraph_bank #(.TICK_CYC(10), .HOLD_MS(500)) i_bas_bargraph_bank (.clk_sys_in,
		.rst_n_in, .meas_in, .max_in, .min_in, .disp_sel_in, .disp_power_on_in,
		.disp_switch_in, .run_or_adj_in, .keys_in, .ret_time_s_in, .mtype_in,
		.meter_upper_in, .meter_lower_in, .test_level_in, .test_enable_in,
		.bank_method_in, .set_protect_in, .key_bank_in, .bank_sel_bit0(ev_bank[0]),
		.bank_sel_bit1(ev_bank[1]), .bank_sel_bit2(ev_bank[2]), .bank_thresh_edit,
		.run_thresh_wr_in, .edit_bank_in, .thresh_wdata_in, .copy_go_in, .copy_src_in,
		.segs_out, .disp_sel_out, .test_value_out, .test_active_out, .active_bank_out,
		.thresh_out, .cmp_out, .bank_lit_out, .method_visible_out, .edit_refused_out);
	initial
	begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk_sys_in);
		s = 1'b1;
		@(negedge clk_sys_in);
		s = 1'b0;
	endtask
	task automatic t_banks;
		bank_method_in = bas_pkg::BM_EVENT;
		key_bank_in = 3'h2;
		for (int b = 0; b < 8; b++)
		begin
			i_bas_partner.set_bank(b[2:0]);
			cyc(2);
			chk("event_bank", b, active_bank_out);
		end
		chk("lamp_on", 1'b1, bank_lit_out);
		chk("method_shown", 1'b1, method_visible_out);
		bank_method_in = bas_pkg::BM_KEYS;
		key_bank_in = 3'h6;
		i_bas_partner.set_bank(3'h1);
		cyc(2);
		chk("key_bank", 3'h6, active_bank_out);
	endtask
	task automatic t_edit;
		bank_method_in = bas_pkg::BM_OFF;
		thresh_wdata_in = T1;
		edit_bank_in = 3'h3;
		@(negedge clk_sys_in);
		bank_thresh_edit = 1'b1;
		@(negedge clk_sys_in);
		bank_thresh_edit = 1'b0;
		chk("refused", 1'b1, edit_refused_out);
		bank_method_in = bas_pkg::BM_KEYS;
		key_bank_in = 3'h3;
		cyc(4);
		chk("bank3_kept", '0, thresh_out);
		pulse(bank_thresh_edit);
		cyc(4);
		chk("bank3_written", T1, thresh_out);
		copy_src_in = 3'h3;
		pulse(copy_go_in);
		key_bank_in = 3'h7;
		cyc(4);
		chk("bank7_copied", T1, thresh_out);
		thresh_wdata_in = T2;
		pulse(run_thresh_wr_in);
		key_bank_in = 3'h0;
		cyc(4);
		chk("bank0_run", T2, thresh_out);
		key_bank_in = 3'h7;
	endtask
	task automatic t_cmp;
		meas_in = 18'h0004B;
		cyc(5);
		chk("cmp_h", 4'h4, cmp_out);
		meas_in = 18'h3FF6A;
		cyc(5);
		chk("cmp_l_ll", 4'h3, cmp_out);
		test_level_in = 1'b1;
		test_enable_in = 1'b1;
		cyc(5);
		chk("test_on", 1'b1, test_active_out);
		chk("cmp_test", 4'h0, cmp_out);
		i_bas_partner.hold_key(1'b1, 100);
		cyc(2);
		chk("test_up", 1'b1, test_value_out > 0);
		v1 = test_value_out;
		i_bas_partner.hold_key(1'b0, 100);
		cyc(2);
		chk("test_down", 1'b1, test_value_out < v1);
		v1 = test_value_out;
		i_bas_partner.hold_key(1'b1, 7000);
		cyc(2);
		chk("test_fast", 1'b1, test_value_out > v1 + 18'sd8);
		test_enable_in = 1'b0;
		cyc(2);
		chk("test_off", 1'b0, test_active_out);
	endtask
	task automatic t_meter;
		mtype_in = bas_pkg::MT_INC;
		meter_upper_in = 18'h003E8;
		meas_in = 18'h003E8;
		cyc(4);
		chk("segs_full", 20'hFFFFF, segs_out);
		meas_in = 18'h001F4;
		cyc(4);
		chk("segs_half", 10, $countones(segs_out));
		chk("segs_inc", 20'hFFC00, segs_out);
		mtype_in = bas_pkg::MT_INCR;
		cyc(4);
		chk("segs_incr", 20'h003FF, segs_out);
		meas_in = 18'h002EE;
		mtype_in = bas_pkg::MT_DEV;
		cyc(4);
		chk("segs_dev", 20'h003E0, segs_out);
		mtype_in = bas_pkg::MT_DEVR;
		cyc(4);
		chk("segs_devr", 20'h07C00, segs_out);
		meter_upper_in = 18'h1FFFF;
		meas_in = 18'h1869F;
		mtype_in = bas_pkg::MT_INC;
		cyc(4);
		chk("segs_clamp", 20'hFFFFF, segs_out);
		meter_upper_in = 18'h003E8;
		mtype_in = bas_pkg::MT_OFF;
		cyc(4);
		chk("segs_off", 20'h00000, segs_out);
		mtype_in = bas_pkg::MT_INC;
	endtask
	task automatic t_ret(input logic [6:0] ret);
		int n;
		ret_time_s_in = ret;
		max_in = 18'h003E8;
		meas_in = 18'h00000;
		disp_sel_in = 2'h1;
		pulse(disp_switch_in);
		cyc(4);
		chk("segs_max", 20'hFFFFF, segs_out);
		cyc(9000);
		chk("disp_held", 2'h1, disp_sel_out);
		n = 0;
		if (ret == 7'h00)
			cyc(3000);
		else
			while (disp_sel_out !== 2'h0 && n < 3000)
			begin
				cyc(1);
				n++;
			end
		chk("disp_return", (ret == 7'h00) ? 2'h1 : 2'h0, disp_sel_out);
	endtask
	task automatic end_of_test;
		$display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		{rst_n_in, disp_switch_in, test_level_in, test_enable_in, bank_thresh_edit} = '0;
		{run_thresh_wr_in, copy_go_in, key_bank_in, edit_bank_in, copy_src_in} = '0;
		{meas_in, max_in, min_in, meter_upper_in, meter_lower_in} = '0;
		{disp_sel_in, disp_power_on_in, ret_time_s_in, thresh_wdata_in} = '0;
		run_or_adj_in = 1'b1;
		set_protect_in = 1'b1;
		mtype_in = bas_pkg::MT_OFF;
		bank_method_in = bas_pkg::BM_OFF;
		cyc(2);
		rst_n_in = 1'b1;
		cyc(2);
		chk("method_hidden", 1'b0, method_visible_out);
		chk("lamp_off", 1'b0, bank_lit_out);
		set_protect_in = 1'b0;
		t_banks();
		t_edit();
		t_cmp();
		t_meter();
		t_ret(7'h01);
		t_ret(7'h00);
		end_of_test();
	end
endmodule
